// *** pkg/fls_pkg.sv ***
package fls_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_MHZ             = 125;
    localparam int unsigned FLASH_WRITE_MIN_NS  = 3700000;
    localparam int unsigned FLASH_WRITE_MAX_NS  = 4500000;
    // least time rounds up, longest time rounds down
    localparam int unsigned FLASH_WRITE_MIN_CYC = (FLASH_WRITE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned FLASH_WRITE_MAX_CYC = (FLASH_WRITE_MAX_NS * CLK_MHZ) / 1000;
    localparam int unsigned TIMER_W             = 20;

    // arming windows, counted from the first cycle after the control write
    localparam logic [2:0] WIN_FIRST  = 3'h1;
    localparam logic [2:0] LPM_WINDOW = 3'h3;
    localparam logic [2:0] SPM_WINDOW = 3'h4;
    localparam logic [2:0] WIN_STEP   = 3'h1;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0]  REG_CTRL_OFS      = 8'h00;
    localparam int unsigned CTRL_PROG_EN_BIT  = 0;
    localparam int unsigned CTRL_LOCK_SET_BIT = 3;
    localparam int unsigned CTRL_SIG_READ_BIT = 5;
    localparam int unsigned CTRL_BUSY_BIT     = 6;
    localparam logic [31:0] WB_ZERO           = 32'h0000_0000;

    // ****************************************************************
    // readback addresses
    // ****************************************************************
    localparam logic [15:0] Z_FUSE_LOW   = 16'h0000;
    localparam logic [15:0] Z_LOCK       = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT   = 16'h0002;
    localparam logic [15:0] Z_FUSE_HIGH  = 16'h0003;
    localparam logic [15:0] SIG_MFR      = 16'h0000;
    localparam logic [15:0] SIG_OSCCAL   = 16'h0001;
    localparam logic [15:0] SIG_FLASHSZ  = 16'h0002;
    localparam logic [15:0] SIG_DEVICE   = 16'h0004;
    localparam logic [15:0] SIG_TOFFSET  = 16'h0005;
    localparam logic [15:0] SIG_TGAIN    = 16'h0007;
    localparam logic [15:0] SIG_LOT_LO   = 16'h000E;
    localparam logic [15:0] SIG_LOT_HI   = 16'h0013;
    localparam logic [15:0] SIG_VAMB_L   = 16'h003C;
    localparam logic [15:0] SIG_VAMB_H   = 16'h003D;
    localparam logic [15:0] SIG_VHOT_L   = 16'h003E;
    localparam logic [15:0] SIG_VHOT_H   = 16'h003F;
    localparam logic [2:0]  LOT_IDX_ADJ  = 3'h2;
    localparam logic [7:0]  BYTE_ONES    = 8'hFF;
    localparam logic [3:0]  NIBBLE_ONES  = 4'hF;
    // lock write touches bits 5..2 only
    localparam logic [7:0]  LOCK_KEEP    = 8'hC3;
    localparam logic [7:0]  LOCK_RESET   = 8'hFF;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        ARM_IDLE = 2'b00,
        ARM_LOCK = 2'b01,
        ARM_SIG  = 2'b11,
        ARM_SPM  = 2'b10
    } fls_arm_type;

    typedef struct packed {
        logic [7:0]      oscCal;
        logic [7:0]      tempOffset;
        logic [7:0]      tempGain;
        logic [5:0][7:0] lotChars;
        logic [15:0]     vrefAmb;
        logic [15:0]     vrefHot;
    } fls_sigTrim_type;

    typedef struct packed {
        logic [7:0] fuseLow;
        logic [7:0] fuseHigh;
        logic [3:0] fuseExt;
    } fls_fuse_type;

endpackage : fls_pkg

// *** verilog/fls_write_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

// flash programming timer and lock byte store; power-on reset only
module fls_write_timer #(
    parameter int unsigned WRITE_CYCLES = fls_pkg::FLASH_WRITE_MIN_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       powerOnRst_b,
    input  wire logic       start,
    input  wire logic [7:0] newLock,
    output logic            busy,
    output logic [7:0]      lockBits
);
    import fls_pkg::*;

    localparam logic [TIMER_W-1:0] LAST = TIMER_W'(WRITE_CYCLES - 1);
    localparam logic [TIMER_W-1:0] ONE  = TIMER_W'(1);

    logic [TIMER_W-1:0] cntQ, cntD;
    logic               busyQ, busyD;
    logic [7:0]         lockQ, lockD, pendQ, pendD;

    // ****************************************************************
    // next state
    // ****************************************************************
    // system reset does not reach here, so a write in flight always completes
    always_comb begin
        cntD  = cntQ;
        busyD = busyQ;
        lockD = lockQ;
        pendD = pendQ;
        if (busyQ) begin
            if (cntQ == LAST) begin
                busyD = 1'b0;
                lockD = pendQ;
                cntD  = '0;
            end else begin
                cntD = cntQ + ONE;
            end
        end else if (start) begin
            busyD = 1'b1;
            pendD = newLock;
            cntD  = '0;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge powerOnRst_b) begin
        if (!powerOnRst_b) begin
            cntQ  <= '0;
            busyQ <= 1'b0;
            lockQ <= LOCK_RESET;
            pendQ <= LOCK_RESET;
        end else begin
            cntQ  <= cntD;
            busyQ <= busyD;
            lockQ <= lockD;
            pendQ <= pendD;
        end
    end

    assign busy     = busyQ;
    assign lockBits = lockQ;

endmodule : fls_write_timer

`default_nettype wire

// *** verilog/fls_readback.sv ***
`timescale 1ns/10ps
`default_nettype none

// Contract
// - armed lock read with pointer 0x0001, load in three cycles returns lock bits.
// - lock arming clears on readback, on a store, or with no store in four; no load in three alone does not clear it.
// - once disarmed, loads return ordinary flash contents.
// - armed lock read with pointer 0x0000 returns fuse low byte.
// - armed lock read with pointer 0x0003 returns all eight fuse high bits.
// - pointer 0x0002 returns extended fuse in bits 3..0, upper nibble no fuse.
// - programmed fuse and lock bits read as 0, unprogrammed as 1.
// - signature arming plus load within three cycles returns the addressed signature byte.
// - signature arming clears after the read or after three idle cycles.
// - signature 0x00 maker, 0x02 flash size, 0x04 device identifier.
// - signature 0x01 oscillator calibration; 0x03 and 0x06 reserved.
// - signature 0x05 temperature offset, 0x07 temperature gain.
// - signature 0x0E..0x13 lot number, leftmost character at 0x0F.
// - 0x3C/0x3D ambient, 0x3E/0x3F hot reference voltage, low byte first.
// - lock writes last between 3.7 ms and 4.5 ms.
// - system reset does not abort a flash write in progress.
// - EEPROM write in progress blocks fuse and lock readback.
module fls_readback #(
    parameter logic [7:0]  MFR_ID       = 8'h5A,  // arbitrary value
    parameter logic [7:0]  FLASH_SIZE_ID = 8'h21, // arbitrary value
    parameter logic [7:0]  DEVICE_ID    = 8'h37,  // arbitrary value
    parameter int unsigned WRITE_CYCLES = fls_pkg::FLASH_WRITE_MIN_CYC
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_b,
    input  wire logic                     powerOnRst_b,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [7:0]               wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic [31:0]                   wb_dat_o,
    output logic                          wb_ack_o,
    input  wire logic                     lpmReq,
    input  wire logic [15:0]              lpmAddr,
    input  wire logic [7:0]               flashData,
    input  wire logic                     spmReq,
    input  wire logic [7:0]               spmData,
    input  wire logic                     eeprom_write_busy,
    input  wire fls_pkg::fls_fuse_type    fuseBytes,
    input  wire fls_pkg::fls_sigTrim_type sigTrim,
    output logic [7:0]                    lpmData,
    output logic                          lpmValid,
    output logic                          lpmFromConfig,
    output logic                          flashBusy
);
    import fls_pkg::*;

    fls_arm_type armQ, armD;
    logic [2:0]  winQ, winD;
    logic        ackQ, ackD;
    logic [31:0] datQ, datD;
    logic [7:0]  lpmDataQ, lpmDataD;
    logic        lpmValidQ, lpmValidD;
    logic        fromCfgQ, fromCfgD;
    logic        wbHit, ctrlWrite, lockStart, busyW;
    logic [7:0]  lockBits, newLock;

    // ****************************************************************
    // signature row lookup
    // ****************************************************************
    function automatic logic [7:0] sigByte(input logic [15:0] a, input fls_sigTrim_type t);
        logic [2:0] idx;
        idx = 3'(a[2:0] + LOT_IDX_ADJ);
        sigByte = BYTE_ONES;
        if (a == SIG_MFR) sigByte = MFR_ID;
        else if (a == SIG_FLASHSZ) sigByte = FLASH_SIZE_ID;
        else if (a == SIG_DEVICE) sigByte = DEVICE_ID;
        // calibration, reserved ones read all ones
        else if (a == SIG_OSCCAL) sigByte = t.oscCal;
        else if (a == SIG_TOFFSET) sigByte = t.tempOffset;
        else if (a == SIG_TGAIN) sigByte = t.tempGain;
        // lot characters, index 1 is leftmost
        else if (a >= SIG_LOT_LO && a <= SIG_LOT_HI) sigByte = t.lotChars[idx];
        // reference voltages, low byte at even address
        else if (a == SIG_VAMB_L) sigByte = t.vrefAmb[7:0];
        else if (a == SIG_VAMB_H) sigByte = t.vrefAmb[15:8];
        else if (a == SIG_VHOT_L) sigByte = t.vrefHot[7:0];
        else if (a == SIG_VHOT_H) sigByte = t.vrefHot[15:8];
    endfunction : sigByte

    // config byte map
    // stored bits already read 0 when programmed, so no inversion here
    function automatic logic [7:0] cfgByte(input logic [15:0] a, input fls_fuse_type f,
                                           input logic [7:0] lk);
        cfgByte = BYTE_ONES;
        if (a == Z_LOCK) cfgByte = lk;
        else if (a == Z_FUSE_LOW) cfgByte = f.fuseLow;
        else if (a == Z_FUSE_HIGH) cfgByte = f.fuseHigh;
        else if (a == Z_FUSE_EXT) cfgByte = {NIBBLE_ONES, f.fuseExt};
    endfunction : cfgByte

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    // writes are refused while the eeprom or a flash write is busy
    assign wbHit     = wb_cyc_i & wb_stb_i & ~ackQ;
    assign ctrlWrite = wbHit & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_CTRL_OFS)
                       & ~eeprom_write_busy & ~busyW;

    always_comb begin
        ackD = wbHit;
        datD = datQ;
        if (wbHit && !wb_we_i) begin
            datD = WB_ZERO;
            if (wb_adr_i == REG_CTRL_OFS) begin
                datD[CTRL_PROG_EN_BIT]  = (armQ != ARM_IDLE);
                datD[CTRL_LOCK_SET_BIT] = (armQ == ARM_LOCK);
                datD[CTRL_SIG_READ_BIT] = (armQ == ARM_SIG);
                datD[CTRL_BUSY_BIT]     = busyW;
            end
        end
    end

    // ****************************************************************
    // arming window and load steering
    // ****************************************************************
    always_comb begin
        armD      = armQ;
        winD      = winQ;
        lockStart = 1'b0;
        newLock   = lockBits & (spmData | LOCK_KEEP);
        lpmValidD = lpmReq;
        lpmDataD  = lpmReq ? flashData : lpmDataQ;
        fromCfgD  = 1'b0;
        case (armQ)
            ARM_IDLE: begin
                // window starts at one on the next cycle
                if (ctrlWrite && wb_dat_i[CTRL_PROG_EN_BIT]) begin
                    winD = WIN_FIRST;
                    if (wb_dat_i[CTRL_SIG_READ_BIT]) armD = ARM_SIG;
                    else if (wb_dat_i[CTRL_LOCK_SET_BIT]) armD = ARM_LOCK;
                    else armD = ARM_SPM;
                end
            end
            ARM_LOCK: begin
                // lock and fuse readback, blocked by eeprom write
                if (lpmReq && winQ <= LPM_WINDOW) begin
                    if (!eeprom_write_busy) begin
                        lpmDataD = cfgByte(lpmAddr, fuseBytes, lockBits);
                        fromCfgD = 1'b1;
                    end
                    armD = ARM_IDLE;
                end else if (spmReq) begin
                    // lock write handed to the timer
                    lockStart = 1'b1;
                    armD      = ARM_IDLE;
                end else if (winQ == SPM_WINDOW) begin
                    armD = ARM_IDLE;
                end else begin
                    winD = 3'(winQ + WIN_STEP);
                end
            end
            ARM_SIG: begin
                if (lpmReq) begin
                    lpmDataD = sigByte(lpmAddr, sigTrim);
                    fromCfgD = 1'b1;
                    armD     = ARM_IDLE;
                end else if (winQ == LPM_WINDOW) begin
                    armD = ARM_IDLE;
                end else begin
                    winD = 3'(winQ + WIN_STEP);
                end
            end
            ARM_SPM: begin
                // page operations live elsewhere; only the window is kept
                if (spmReq || winQ == SPM_WINDOW) armD = ARM_IDLE;
                else winD = 3'(winQ + WIN_STEP);
            end
            default: begin
                armD = ARM_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            armQ      <= ARM_IDLE;
            winQ      <= WIN_FIRST;
            ackQ      <= 1'b0;
            datQ      <= WB_ZERO;
            lpmDataQ  <= BYTE_ONES;
            lpmValidQ <= 1'b0;
            fromCfgQ  <= 1'b0;
        end else begin
            armQ      <= armD;
            winQ      <= winD;
            ackQ      <= ackD;
            datQ      <= datD;
            lpmDataQ  <= lpmDataD;
            lpmValidQ <= lpmValidD;
            fromCfgQ  <= fromCfgD;
        end
    end

    // timer kept on power-on reset only
    fls_write_timer #(
        .WRITE_CYCLES (WRITE_CYCLES)
    ) uTimer (
        .clk_sys      (clk_sys),
        .powerOnRst_b (powerOnRst_b),
        .start        (lockStart),
        .newLock      (newLock),
        .busy         (busyW),
        .lockBits     (lockBits)
    );

    assign wb_dat_o      = datQ;
    assign wb_ack_o      = ackQ;
    assign lpmData       = lpmDataQ;
    assign lpmValid      = lpmValidQ;
    assign lpmFromConfig = fromCfgQ;
    assign flashBusy     = busyW;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    lock_read_a: assert property (armQ == ARM_LOCK && lpmReq && winQ <= LPM_WINDOW
        && lpmAddr == Z_LOCK && !eeprom_write_busy |=> lpmValid && lpmFromConfig
        && lpmData == $past(lockBits))
        else $error("lock readback wrong");

    lock_expire_a: assert property (armQ == ARM_LOCK && winQ == SPM_WINDOW |=> armQ == ARM_IDLE)
        else $error("lock arming outlived window");

    normal_load_a: assert property (armQ == ARM_IDLE && lpmReq
        |=> lpmValid && !lpmFromConfig && lpmData == $past(flashData))
        else $error("disarmed load not from flash");

    fuse_low_a: assert property (armQ == ARM_LOCK && lpmReq && winQ <= LPM_WINDOW
        && lpmAddr == Z_FUSE_LOW && !eeprom_write_busy |=> lpmData == $past(fuseBytes.fuseLow))
        else $error("fuse low byte wrong");

    fuse_high_a: assert property (armQ == ARM_LOCK && lpmReq && winQ <= LPM_WINDOW
        && lpmAddr == Z_FUSE_HIGH && !eeprom_write_busy |=> lpmData == $past(fuseBytes.fuseHigh))
        else $error("fuse high byte wrong");

    fuse_ext_a: assert property (armQ == ARM_LOCK && lpmReq && winQ <= LPM_WINDOW
        && lpmAddr == Z_FUSE_EXT && !eeprom_write_busy
        |=> lpmData == {NIBBLE_ONES, $past(fuseBytes.fuseExt)})
        else $error("extended fuse byte wrong");

    sig_expire_a: assert property (armQ == ARM_SIG && !lpmReq && winQ == LPM_WINDOW
        |=> armQ == ARM_IDLE)
        else $error("signature arming outlived window");

    sig_maker_a: assert property (armQ == ARM_SIG && lpmReq && lpmAddr == SIG_MFR
        |=> lpmFromConfig && lpmData == MFR_ID && armQ == ARM_IDLE)
        else $error("maker identifier wrong");

    sig_gain_a: assert property (armQ == ARM_SIG && lpmReq && lpmAddr == SIG_TGAIN
        |=> lpmFromConfig && lpmData == $past(sigTrim.tempGain))
        else $error("temperature gain byte wrong");

    ee_block_a: assert property (armQ == ARM_LOCK && lpmReq && eeprom_write_busy
        |=> !lpmFromConfig)
        else $error("readback during eeprom write");

    win_start_a: assert property (armQ == ARM_IDLE && ctrlWrite && wb_dat_i[CTRL_PROG_EN_BIT]
        |=> armQ != ARM_IDLE && winQ == WIN_FIRST)
        else $error("window did not start at one");

    bus_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    lock_read_c: cover property (armQ == ARM_LOCK && lpmReq && lpmAddr == Z_LOCK);
    sig_read_c:  cover property (armQ == ARM_SIG && lpmReq);
    lock_wr_c:   cover property (lockStart);
    expire_c:    cover property (armQ == ARM_LOCK && winQ == SPM_WINDOW ##1 armQ == ARM_IDLE);

endmodule : fls_readback

`default_nettype wire

// *** verification/fls_core_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// cpu side of the readback path: load and store strokes, each one clock wide
module fls_core_model (
    input  wire logic        clk_sys,
    output logic             lpmReq,
    output logic [15:0]      lpmAddr,
    output logic [7:0]       flashData,
    output logic             spmReq,
    output logic [7:0]       spmData
);
    logic [7:0] spmVal;

    // start quiet so no stroke is seen during reset
    initial begin
        lpmReq  = 1'b0;
        lpmAddr = 16'h0000;
        spmReq  = 1'b0;
        spmVal  = 8'h00;
    end

    // flash byte is a pattern of the pointer; inverted when no load, so stale data never matches
    assign flashData = lpmReq ? (lpmAddr[7:0] ^ 8'hA5) : ~(lpmAddr[7:0] ^ 8'hA5);
    assign spmData   = spmReq ? spmVal : ~spmVal;

    task automatic load(input logic [15:0] addr, input int waitEdges);
        repeat (waitEdges) @(posedge clk_sys);
        lpmReq  <= 1'b1;
        lpmAddr <= addr;
        @(posedge clk_sys);
        lpmReq  <= 1'b0;
    endtask : load

    // store stroke carrying the new lock pattern
    task automatic store(input logic [7:0] val, input int waitEdges);
        repeat (waitEdges) @(posedge clk_sys);
        spmReq <= 1'b1;
        spmVal <= val;
        @(posedge clk_sys);
        spmReq <= 1'b0;
    endtask : store
endmodule : fls_core_model

`default_nettype wire

// *** verification/fls_readback_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module fls_readback_test;
    import fls_pkg::*;

    // ****************************************************************
    // stimulus and design
    // ****************************************************************
    logic            clk_sys;
    logic            rstB;
    logic            porB;
    logic            wbCyc;
    logic            wbStb;
    logic            wbWe;
    logic [7:0]      wbAdr;
    logic [31:0]     wbDat;
    logic [3:0]      wbSel;
    logic [3:0]      selUse;
    logic [31:0]     wb_dat_o;
    logic            wb_ack_o;
    logic            lpmReq;
    logic [15:0]     lpmAddr;
    logic [7:0]      flashData;
    logic            spmReq;
    logic [7:0]      spmData;
    logic            eeBusy;
    fls_fuse_type    fuseBytes;
    fls_sigTrim_type sigTrim;
    logic [7:0]      lpmData;
    logic            lpmValid;
    logic            lpmFromConfig;
    logic            flashBusy;
    int              numErrors;
    int              testsRun;
    logic [7:0]      cfgExp [4]  = '{8'h62, 8'hFF, 8'hF9, 8'hD9};
    logic [15:0]     sigAdr [15] = '{16'h00, 16'h01, 16'h02, 16'h03, 16'h04, 16'h05, 16'h06, 16'h07,
                                     16'h0E, 16'h0F, 16'h13, 16'h3C, 16'h3D, 16'h3E, 16'h3F};
    logic [7:0]      sigExp [15] = '{8'hC1, 8'h6C, 8'hC2, 8'hFF, 8'hC3, 8'h13, 8'hFF, 8'h80,
                                     8'h30, 8'h31, 8'h35, 8'h00, 8'h0A, 8'h19, 8'h0A};

    // identifier values are arbitrary; short write time keeps the run brief
    fls_readback #(.MFR_ID(8'hC1), .FLASH_SIZE_ID(8'hC2), .DEVICE_ID(8'hC3), .WRITE_CYCLES(12)) DUT (
        .clk_sys(clk_sys), .rst_b(rstB), .powerOnRst_b(porB), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .lpmReq(lpmReq), .lpmAddr(lpmAddr), .flashData(flashData),
        .spmReq(spmReq), .spmData(spmData), .eeprom_write_busy(eeBusy), .fuseBytes(fuseBytes),
        .sigTrim(sigTrim), .lpmData(lpmData), .lpmValid(lpmValid), .lpmFromConfig(lpmFromConfig),
        .flashBusy(flashBusy));

    fls_core_model core (.clk_sys(clk_sys), .lpmReq(lpmReq), .lpmAddr(lpmAddr),
        .flashData(flashData), .spmReq(spmReq), .spmData(spmData));

    // 125 MHz clock and time-zero values
    initial begin
        clk_sys   = 1'b0;
        rstB      = 1'b0;
        porB      = 1'b0;
        wbCyc     = 1'b0;
        wbStb     = 1'b0;
        wbWe      = 1'b0;
        wbAdr     = 8'h00;
        wbDat     = 32'h0000_0000;
        wbSel     = 4'h0;
        selUse    = 4'hF;
        eeBusy    = 1'b0;
        numErrors = 0;
        testsRun  = 0;
        fuseBytes = '{fuseLow: 8'h62, fuseHigh: 8'hD9, fuseExt: 4'h9};
        sigTrim   = '{oscCal: 8'h6C, tempOffset: 8'h13, tempGain: 8'h80, lotChars: 48'h35_34_33_32_31_30,
                      vrefAmb: 16'h0A00, vrefHot: 16'h0A19};
        forever #4 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // classic single cycle; held until ack is sampled high
    task automatic wbCycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe  <= we;
        wbAdr <= adr;
        wbDat <= dat;
        wbSel <= selUse;
        n = 0;
        // no cycle limit here; a lost ack is left to the watchdog
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        // ack is registered, so it is seen on the second edge
        chk("bus ack latency", 32'd2, n);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask : wbCycle

    // one load; flash answers when config is false
    task automatic doLoad(input logic [15:0] adr, input int w, input logic cfg, input logic [7:0] exp);
        core.load(adr, w);
        @(negedge clk_sys);
        chk("lpmValid", 32'h1, {31'h0, lpmValid});
        chk("lpmFromConfig", {31'h0, cfg}, {31'h0, lpmFromConfig});
        chk("lpmData", {24'h0, cfg ? exp : adr[7:0] ^ 8'hA5}, {24'h0, lpmData});
        @(posedge clk_sys);
    endtask : doLoad

    task automatic closeOut();
        $display("checks %0d mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : closeOut

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin : mainSeq
        logic [31:0] rd;
        int          cnt;
        repeat (8) @(posedge clk_sys);
        rstB <= 1'b1;
        porB <= 1'b1;
        wbCycle(1'b0, REG_CTRL_OFS, 32'h0, rd);
        chk("ctrl idle", 32'h0, rd);
        wbCycle(1'b0, 8'h04, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        // plain store mode and lock mode show in the control read
        wbCycle(1'b1, REG_CTRL_OFS, 32'h01, rd);
        wbCycle(1'b0, REG_CTRL_OFS, 32'h0, rd);
        chk("ctrl store mode", 32'h01, rd);
        wbCycle(1'b1, REG_CTRL_OFS, 32'h09, rd);
        wbCycle(1'b0, REG_CTRL_OFS, 32'h0, rd);
        chk("ctrl armed", 32'h09, rd);
        // refused control writes leave the arming idle
        selUse = 4'h0;
        wbCycle(1'b1, REG_CTRL_OFS, 32'h09, rd);
        selUse = 4'hF;
        wbCycle(1'b0, REG_CTRL_OFS, 32'h0, rd);
        chk("ctrl without sel", 32'h0, rd);
        eeBusy <= 1'b1;
        wbCycle(1'b1, REG_CTRL_OFS, 32'h09, rd);
        wbCycle(1'b0, REG_CTRL_OFS, 32'h0, rd);
        eeBusy <= 1'b0;
        chk("ctrl during eeprom write", 32'h0, rd);
        // loads alternate between the second and third window cycles
        for (int i = 0; i < 4; i++) begin
            wbCycle(1'b1, REG_CTRL_OFS, 32'h09, rd);
            doLoad(i[15:0], i % 2, 1'b1, cfgExp[i]);
        end
        wbCycle(1'b1, REG_CTRL_OFS, 32'h09, rd);
        doLoad(Z_LOCK, 2, 1'b0, 8'h00);
        for (int i = 0; i < 15; i++) begin
            wbCycle(1'b1, REG_CTRL_OFS, 32'h21, rd);
            doLoad(sigAdr[i], i % 2, 1'b1, sigExp[i]);
        end
        wbCycle(1'b1, REG_CTRL_OFS, 32'h21, rd);
        doLoad(SIG_MFR, 2, 1'b0, 8'h00);
        wbCycle(1'b0, REG_CTRL_OFS, 32'h0, rd);
        chk("ctrl after expiry", 32'h0, rd);
        wbCycle(1'b1, REG_CTRL_OFS, 32'h09, rd);
        eeBusy <= 1'b1;
        doLoad(Z_FUSE_HIGH, 0, 1'b0, 8'h00);
        eeBusy <= 1'b0;
        // lock write on the last store cycle, system reset in mid-write
        wbCycle(1'b1, REG_CTRL_OFS, 32'h09, rd);
        core.store(8'hF3, 2);
        fork
            begin
                repeat (3) @(posedge clk_sys);
                rstB <= 1'b0;
                @(posedge clk_sys);
                rstB <= 1'b1;
            end
        join_none
        cnt = 0;
        repeat (40) begin
            @(negedge clk_sys);
            if (flashBusy === 1'b1) cnt++;
        end
        chk("write cycles", 32'd12, cnt);
        wbCycle(1'b1, REG_CTRL_OFS, 32'h09, rd);
        doLoad(Z_LOCK, 0, 1'b1, 8'hF3);
        closeOut();
    end

    // a hang ends the run the same way
    initial begin
        #200us;
        numErrors++;
        $display("timeout waiting for the sequence");
        closeOut();
    end
endmodule : fls_readback_test

`default_nettype wire
